//--- pkg/reader_fifo_params.svh
// Constants of the reader FIFO level and data port block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef READER_FIFO_PARAMS_SVH
`define READER_FIFO_PARAMS_SVH

// Register offsets
`define REG_CONFIG          8'h02
`define REG_THRESHOLD       8'h03
`define REG_COUNT           8'h04
`define REG_PORT            8'h05
`define REG_IRQ_STATUS      8'h06
`define REG_IRQ_CLEAR       8'h07
`define REG_IRQ_ENABLE      8'h08

// Configuration register fields
`define CFG_DEPTH_BIT       7
`define CFG_HIGH_BIT        6
`define CFG_LOW_BIT         5
`define CFG_PURGE_BIT       4
`define CFG_THR_HI_BIT      2
`define CFG_CNT_HI_MSB      1
`define CFG_CNT_HI_LSB      0

// Interrupt status fields
`define IRQ_LOW_BIT         0
`define IRQ_HIGH_BIT        1
`define IRQ_OVER_BIT        2
`define IRQ_UNDER_BIT       3
`define IRQ_W               4

// Widths and depths
`define DATA_W              8
`define ADDR_W              8
`define IDX_W               9
`define CNT_W               10
`define THR_W               9
`define FIFO_SMALL_DEPTH    255
`define FIFO_LARGE_DEPTH    512

// Reset values
`define THRESHOLD_RESET     9'h008
`define COUNT_RESET         10'h000
`define DATA_RESET          8'h00
`define IRQ_RESET           4'h0
`define PTR_RESET           8'h00

`endif

//--- pkg/reader_fifo_pkg.sv
// Types of the reader FIFO level and data port block.
// Assumes the params header is on the include path.
`include "reader_fifo_params.svh"

package reader_fifo_pkg;

    typedef struct packed {
        logic [`THR_W-1:0]  threshold;
        logic               depth_sel;
        logic [`IDX_W-1:0]  wr_idx;
        logic [`IDX_W-1:0]  rd_idx;
        logic [`CNT_W-1:0]  count;
        logic               low_warn;
        logic               high_warn;
        logic [`IRQ_W-1:0]  irq_status;
        logic [`IRQ_W-1:0]  irq_enable;
        logic [`DATA_W-1:0] rdata;
        logic [`ADDR_W-1:0] ptr;
    } level_state_type;

endpackage

//--- verilog/fifo_store_mem.sv
// Flip-flop byte store for the reader FIFO, indexed write and read.
// Assumes the caller keeps indices below DEPTH and never writes a full store.
`timescale 1ns/1ns
`include "reader_fifo_params.svh"

module fifo_store_mem #(
    parameter int DEPTH = `FIFO_LARGE_DEPTH,
    parameter int WIDTH = `DATA_W,
    parameter int IDXW  = `IDX_W
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Write side
    input  wire logic             wr_en,
    input  wire logic [IDXW-1:0]  wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read side
    input  wire logic [IDXW-1:0]  rd_idx,
    output logic      [WIDTH-1:0] rd_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } store_state_type;

    store_state_type s_r;
    store_state_type s_nxt;

    generate
        if (DEPTH < 2 || DEPTH > (1 << IDXW)) begin : g_bad_depth
            $error("fifo_store_mem: DEPTH does not fit the index width");
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        if (wr_en) begin
            s_nxt.mem[wr_idx] = wr_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.mem[rd_idx];

endmodule

//--- verilog/reader_fifo_level_port.sv
// Host side FIFO registers of a contactless reader: threshold, fill count,
// non-advancing data port, depth selection, warnings and interrupts.
// Assumes a synchronous host register port on CLOCK, one strobe at a time.
//
// Notes on behaviour
// - Threshold bit 8 sits in config bit 2, used only in large mode.
// - Count bits 9:8 read in config bits 1:0, only in large mode.
// - Config depth select bit switches to the large FIFO mode.
// - Eight-bit read/write warning threshold register at 03h.
// - Low warning reads one while stored bytes are at or below threshold.
// - Fill count register at 04h, reset 00h, shows bytes held.
// - Data port write adds one byte unless full, data port read removes one unless empty.
// - Data port accesses at 05h leave the address pointer at 05h.
// - Data port is eight bits: writes push, reads pop the oldest byte.
// - Writing one to config bit 4 empties the FIFO; reads as zero.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "reader_fifo_params.svh"

module reader_fifo_level_port
    import reader_fifo_pkg::*;
#(
    parameter int SMALL_DEPTH = `FIFO_SMALL_DEPTH,
    parameter int LARGE_DEPTH = `FIFO_LARGE_DEPTH
) (
    // Clock and reset
    input  wire logic               CLOCK,
    input  wire logic               RESET_N,
    // Host register port
    input  wire logic [`ADDR_W-1:0] ADDR,
    input  wire logic               SEQ,
    input  wire logic [`DATA_W-1:0] WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output logic      [`DATA_W-1:0] RDATA,
    output logic      [`ADDR_W-1:0] ADDR_PTR,
    // Status and interrupt
    output logic                    LOW_WARNING,
    output logic                    HIGH_WARNING,
    output logic                    IRQ
);

    level_state_type s_r;
    level_state_type s_nxt;

    logic [`ADDR_W-1:0] eff_addr;
    logic [`CNT_W-1:0]  depth_eff;
    logic               full;
    logic               empty;
    logic               port_hit;
    logic               push;
    logic               pop;
    logic               overrun;
    logic               underrun;
    logic               purge;
    logic [`DATA_W-1:0] mem_rd;
    logic [`DATA_W-1:0] rd_val;
    logic [`IRQ_W-1:0]  events;
    logic [`IRQ_W-1:0]  clear_mask;
    logic [`CNT_W-1:0]  nxt_depth;
    logic [`CNT_W-1:0]  nxt_thr;
    logic               nxt_low;
    logic               nxt_high;

    // Elaboration checks on the depths
    generate
        if (SMALL_DEPTH < 2 || SMALL_DEPTH >= LARGE_DEPTH) begin : g_bad_small
            $error("reader_fifo_level_port: SMALL_DEPTH must be at least 2 and below LARGE_DEPTH");
        end
        if (LARGE_DEPTH > `FIFO_LARGE_DEPTH) begin : g_bad_large
            $error("reader_fifo_level_port: LARGE_DEPTH exceeds the index width");
        end
    endgenerate

    // Byte storage
    fifo_store_mem #(
        .DEPTH   (LARGE_DEPTH),
        .WIDTH   (`DATA_W),
        .IDXW    (`IDX_W)
    ) u_store (
        .clock   (CLOCK),
        .reset_n (RESET_N),
        .wr_en   (push),
        .wr_idx  (s_r.wr_idx),
        .wr_data (WDATA),
        .rd_idx  (s_r.rd_idx),
        .rd_data (mem_rd)
    );

    // Access decode and FIFO conditions
    always_comb begin
        eff_addr  = SEQ ? s_r.ptr : ADDR;
        depth_eff = s_r.depth_sel ? `CNT_W'(LARGE_DEPTH) : `CNT_W'(SMALL_DEPTH);
        full      = (s_r.count == depth_eff);
        empty     = (s_r.count == `COUNT_RESET);
        port_hit  = (eff_addr == `REG_PORT);
        push      = WR && port_hit && !full;
        pop       = RD && port_hit && !empty;
        overrun   = WR && port_hit && full;
        underrun  = RD && port_hit && empty;
        purge     = WR && (eff_addr == `REG_CONFIG)
                    && (WDATA[`CFG_PURGE_BIT]
                        || (WDATA[`CFG_DEPTH_BIT] != s_r.depth_sel));
    end

    // Read data mux
    always_comb begin
        rd_val = `DATA_RESET;
        case (eff_addr)
            `REG_CONFIG: begin
                rd_val[`CFG_DEPTH_BIT] = s_r.depth_sel;
                rd_val[`CFG_HIGH_BIT]  = s_r.high_warn;
                rd_val[`CFG_LOW_BIT]   = s_r.low_warn;
                rd_val[`CFG_PURGE_BIT] = 1'b0;
                if (s_r.depth_sel) begin
                    rd_val[`CFG_THR_HI_BIT] = s_r.threshold[`THR_W-1];
                    rd_val[`CFG_CNT_HI_MSB:`CFG_CNT_HI_LSB] =
                        s_r.count[`CNT_W-1:`DATA_W];
                end
            end
            `REG_THRESHOLD: begin
                rd_val = s_r.threshold[`DATA_W-1:0];
            end
            `REG_COUNT: begin
                rd_val = s_r.count[`DATA_W-1:0];
            end
            `REG_PORT: begin
                rd_val = empty ? `DATA_RESET : mem_rd;
            end
            `REG_IRQ_STATUS: begin
                rd_val[`IRQ_W-1:0] = s_r.irq_status;
            end
            `REG_IRQ_ENABLE: begin
                rd_val[`IRQ_W-1:0] = s_r.irq_enable;
            end
            default: begin
                rd_val = `DATA_RESET;
            end
        endcase
    end

    // Next state
    always_comb begin
        s_nxt      = s_r;
        events     = `IRQ_RESET;
        clear_mask = `IRQ_RESET;

        // Register writes
        if (WR) begin
            case (eff_addr)
                `REG_CONFIG: begin
                    s_nxt.depth_sel = WDATA[`CFG_DEPTH_BIT];
                    s_nxt.threshold[`THR_W-1] = WDATA[`CFG_THR_HI_BIT];
                end
                `REG_THRESHOLD: begin
                    s_nxt.threshold[`DATA_W-1:0] = WDATA;
                end
                `REG_IRQ_CLEAR: begin
                    clear_mask = WDATA[`IRQ_W-1:0];
                end
                `REG_IRQ_ENABLE: begin
                    s_nxt.irq_enable = WDATA[`IRQ_W-1:0];
                end
                default: begin
                    s_nxt.irq_enable = s_r.irq_enable;
                end
            endcase
        end

        // Push and pop with wrap at the active depth
        if (push) begin
            s_nxt.count  = s_r.count + `CNT_W'(1);
            s_nxt.wr_idx = (`CNT_W'(s_r.wr_idx) == depth_eff - `CNT_W'(1))
                           ? `IDX_W'(0) : s_r.wr_idx + `IDX_W'(1);
        end
        if (pop) begin
            s_nxt.count  = s_r.count - `CNT_W'(1);
            s_nxt.rd_idx = (`CNT_W'(s_r.rd_idx) == depth_eff - `CNT_W'(1))
                           ? `IDX_W'(0) : s_r.rd_idx + `IDX_W'(1);
        end

        // Purge, also taken on a change of depth
        if (purge) begin
            s_nxt.count  = `COUNT_RESET;
            s_nxt.wr_idx = `IDX_W'(0);
            s_nxt.rd_idx = `IDX_W'(0);
        end

        // Warnings from the coming state
        nxt_depth = s_nxt.depth_sel ? `CNT_W'(LARGE_DEPTH) : `CNT_W'(SMALL_DEPTH);
        nxt_thr   = s_nxt.depth_sel ? {1'b0, s_nxt.threshold}
                                    : {2'b00, s_nxt.threshold[`DATA_W-1:0]};
        nxt_low   = (s_nxt.count <= nxt_thr);
        nxt_high  = (nxt_thr >= nxt_depth) ? 1'b1
                    : (s_nxt.count >= nxt_depth - nxt_thr);
        s_nxt.low_warn  = nxt_low;
        s_nxt.high_warn = nxt_high;

        // Sticky events, set wins over clear
        events[`IRQ_LOW_BIT]   = nxt_low && !s_r.low_warn;
        events[`IRQ_HIGH_BIT]  = nxt_high && !s_r.high_warn;
        events[`IRQ_OVER_BIT]  = overrun;
        events[`IRQ_UNDER_BIT] = underrun;
        s_nxt.irq_status = (s_r.irq_status & ~clear_mask) | events;

        // Read data stands one cycle only
        s_nxt.rdata = RD ? rd_val : `DATA_RESET;

        // Address pointer holds on the data port
        if (WR || RD) begin
            s_nxt.ptr = port_hit ? eff_addr : eff_addr + `ADDR_W'(1);
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r.threshold  <= `THRESHOLD_RESET;
            s_r.depth_sel  <= 1'b0;
            s_r.wr_idx     <= `IDX_W'(0);
            s_r.rd_idx     <= `IDX_W'(0);
            s_r.count      <= `COUNT_RESET;
            s_r.low_warn   <= 1'b1;
            s_r.high_warn  <= 1'b0;
            s_r.irq_status <= `IRQ_RESET;
            s_r.irq_enable <= `IRQ_RESET;
            s_r.rdata      <= `DATA_RESET;
            s_r.ptr        <= `PTR_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign RDATA        = s_r.rdata;
    assign ADDR_PTR     = s_r.ptr;
    assign LOW_WARNING  = s_r.low_warn;
    assign HIGH_WARNING = s_r.high_warn;
    assign IRQ          = |(s_r.irq_status & s_r.irq_enable);

endmodule

//--- sim/fifo_level_properties.sv
// Checker for the reader FIFO port: pointer, read data and warning timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns

module fifo_level_checker (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       RESET_N,
    // Host register port
    input wire logic [7:0] ADDR,
    input wire logic       SEQ,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] ADDR_PTR,
    // Status and interrupt
    input wire logic       LOW_WARNING,
    input wire logic       HIGH_WARNING,
    input wire logic       IRQ
);
    wire logic [7:0] eff = SEQ ? ADDR_PTR : ADDR;

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    sequence port_acc;
        (WR || RD) && eff == 8'h05;
    endsequence
    sequence port_pop;
        RD && eff == 8'h05;
    endsequence
    sequence purge_wr;
        WR && eff == 8'h02 && WDATA[4];
    endsequence

    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    a_port_ptr_hold: assert property (port_acc |=> ADDR_PTR == 8'h05)
        else $error("pointer moved on data port access");
    a_ptr_advance: assert property ((WR || RD) && eff != 8'h05 |=> ADDR_PTR == $past(eff) + 8'h01)
        else $error("pointer did not advance");
    a_ptr_steady: assert property (!WR && !RD |=> $stable(ADDR_PTR))
        else $error("pointer moved without access");
    a_warn_steady: assert property (!$past(WR) && !$past(RD) |-> $stable({LOW_WARNING, HIGH_WARNING}))
        else $error("warning moved without access");
    a_purge_low: assert property (purge_wr |=> LOW_WARNING)
        else $error("low warning clear after purge");
    a_empty_pop: assert property (purge_wr ##1 (!WR && !RD) ##1 port_pop |=> RDATA == 8'h00)
        else $error("pop of empty store gave data");
    a_reset_low: assert property ($rose(RESET_N) |-> LOW_WARNING && !IRQ)
        else $error("bad state after reset");
endmodule

bind reader_fifo_level_port fifo_level_checker u_chk (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR), .SEQ(SEQ), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ADDR_PTR(ADDR_PTR), .LOW_WARNING(LOW_WARNING), .HIGH_WARNING(HIGH_WARNING), .IRQ(IRQ));

//--- sim/host_ctrl.sv
// Host controller model: one strobe at a time on the register port.
// Assumes the bench clock; signals change just after a rising edge.
`timescale 1ns/1ns

module host_ctrl (
    // Clock and read data
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    // Register port
    output logic      [7:0] addr,
    output logic            seq,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    initial begin
        addr = 8'h00;
        seq = 1'b0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Released lines show the inverse of the last value
    task automatic wr_reg(input logic s, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        seq <= s;
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
        addr <= ~a;
        #1;
    endtask

    task automatic rd_reg(input logic s, input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        seq <= s;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

//--- sim/tb_top.sv
// Testbench for the reader FIFO port: registers, data port and warnings.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end

module tb_top
    import reader_fifo_pkg::*;
;
    logic       CLOCK = 1'b0;
    logic       RESET_N = 1'b0;
    wire  [7:0] addr, wdata, rdata, addr_ptr;
    wire        seq, wr, rd, low_warning, high_warning, irq;
    logic [7:0] d;
    int         num_errors = 0;
    int         tests_run = 0;

    always #50 CLOCK = ~CLOCK;

    reader_fifo_level_port uut (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(addr), .SEQ(seq), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ADDR_PTR(addr_ptr), .LOW_WARNING(low_warning), .HIGH_WARNING(high_warning), .IRQ(irq));

    host_ctrl u_host (
        .clk(CLOCK), .rdata(rdata), .addr(addr), .seq(seq), .wdata(wdata), .wr(wr), .rd(rd));

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.rd_reg(1'b0, a, v);
        `CHK($sformatf("reg %h", a), e, v)
    endtask

    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            u_host.wr_reg(1'b0, 8'h05, i[7:0]);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge CLOCK);
        RESET_N <= 1'b1;
        chk_rd(8'h04, 8'h00);
        chk_rd(8'h02, 8'h20);
        u_host.wr_reg(1'b0, 8'h03, 8'h02);
        chk_rd(8'h03, 8'h02);
        for (int i = 0; i < 3; i++) begin
            u_host.wr_reg(1'b0, 8'h05, 8'ha0 + i[7:0]);
            `CHK("low", (i < 2), low_warning)
            `CHK("ptr", 8'h05, addr_ptr)
        end
        chk_rd(8'h04, 8'h03);
        for (int i = 0; i < 3; i++) begin
            u_host.rd_reg(1'b1, 8'h00, d);
            `CHK("pop", 8'ha0 + i[7:0], d)
            `CHK("ptr", 8'h05, addr_ptr)
        end
        chk_rd(8'h04, 8'h00);
        push(256);
        chk_rd(8'h04, 8'hff);
        u_host.wr_reg(1'b0, 8'h08, 8'h08);
        chk_rd(8'h08, 8'h08);
        u_host.wr_reg(1'b0, 8'h02, 8'h10);
        u_host.rd_reg(1'b0, 8'h05, d);
        `CHK("empty pop", 8'h00, d)
        `CHK("irq", 1'b1, irq)
        chk_rd(8'h04, 8'h00);
        chk_rd(8'h02, 8'h20);
        u_host.wr_reg(1'b0, 8'h07, 8'h08);
        `CHK("irq clear", 1'b0, irq)
        u_host.wr_reg(1'b0, 8'h08, 8'h00);
        u_host.rd_reg(1'b0, 8'h05, d);
        `CHK("irq mask", 1'b0, irq)
        chk_rd(8'h06, 8'h0f);
        u_host.wr_reg(1'b0, 8'h02, 8'h84);
        chk_rd(8'h02, 8'ha4);
        push(300);
        `CHK("high", 1'b1, high_warning)
        chk_rd(8'h04, 8'h2c);
        chk_rd(8'h02, 8'hc5);
        u_host.wr_reg(1'b0, 8'h02, 8'h04);
        chk_rd(8'h02, 8'h20);
        chk_rd(8'h40, 8'h00);
        `CHK("ptr", 8'h41, addr_ptr)
        finish_test();
    end
endmodule
